// ===== verilog/pagc_top.sv
// Purpose: global control, list 0 sequencing and register file of the converter
// Assumes: APB slave with no wait states; analog core behind the core ports
// Notes: results are written in arrival order of core_valid
//
// Local design decisions: the address map and register access over APB.

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - enable bit 15; registers always accessible
// - flags rise when list results ready
// - stop-in-idle bit halts in idle
// - run-in-sleep bit keeps sleep operation
// - four-bit format selects result layout
// - bit 7 turns on switch pump
// - calibrate bit self-clears after two periods
// - two bits select positive reference
// - bit 12 selects negative reference
// - bit 10 selects indexed or fifo buffer
// - one sample per conversion clock, every other clock at prescaler code zero
// - list 0 enable and global list enable, shared result buffer
// - ready when warmed; busy while converting
// - period is twice prescaler, zero direct
module pagc_top #(parameter int TBL_N = 32) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pagc_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu power state and trigger
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic list0_trigger,
    // analog core
    input wire logic core_ready,
    input wire logic core_valid,
    input wire logic [11:0] core_data,
    output logic core_enable,
    output logic cal_start,
    output logic sample_strobe,
    output logic [5:0] sample_channel,
    output logic switch_pump_enable,
    output logic reference_pump_enable,
    output logic power_level,
    output logic neg_ref_select,
    output logic [2:0] pos_ref_onehot,
    // status
    output logic conversion_busy,
    output logic analog_ready,
    output logic list0_event_flag,
    output logic converter_irq_flag,
    output logic converter_irq
);
    import pagc_pkg::*;
    if (TBL_N != 32) $error("channel table must hold 32 entries");

    typedef enum logic [0:0] {PAGC_IDLE, PAGC_CONV} pagc_state_t;

    logic [DW-1:0] ctl1_r, ctl2_r, ctl3_r, l0ctl_r; // control registers
    logic [5:0] tbl_r [TBL_N]; // channel table entries
    logic l0f_r, irqf_r, irqe_r; // event flags and irq enable
    logic cal_r; // calibrate request bit
    logic [1:0] cal_cnt_r; // ticks seen while calibrating
    logic rdy_r; // analog ready status
    pagc_state_t st_r; // sequencer state
    logic [4:0] iss_r, rcv_r, fifo_r; // issue, receive and fifo indices
    logic sample_r; // sample strobe
    logic [5:0] chan_r; // channel of the strobe
    logic [31:0] prdata_r; // captured read data
    logic wr, rd_setup, acc; // apb phases
    logic halt, tick, done; // block halted, conversion tick, list done
    logic [DW-1:0] rd_val; // read mux value
    logic hit; // address mapped
    pagc_res_if #(.IW(5)) rif ();

    // apb decode
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    // true when the address targets a 32-word window
    function automatic logic in_win(input logic [AW-1:0] a, input logic [4:0] w);
        in_win = (a[11:7] == w) && (a[1:0] == 2'h0);
    endfunction

    // read mux and address map
    always_comb begin
        rd_val = '0;
        hit = 1'b1;
        if (in_win(paddr, WIN_TBL)) begin
            rd_val = {10'h0, tbl_r[paddr[6:2]]};
        end else if (in_win(paddr, WIN_RES)) begin
            rd_val = rif.rdata;
        end else begin
            unique case (paddr)
                OFF_CTL1: rd_val = ctl1_r | (DW'(cal_r) << B_CAL);
                OFF_CTL2: rd_val = ctl2_r;
                OFF_CTL3: rd_val = ctl3_r;
                OFF_STATH: rd_val = DW'({switch_pump_enable, rdy_r, conversion_busy});
                OFF_STATL: rd_val = DW'(l0f_r) << B_L0F;
                OFF_IRQ: rd_val = DW'({irqe_r, irqf_r});
                OFF_L0CTL: rd_val = l0ctl_r;
                default: hit = 1'b0;
            endcase
        end
    end
    assign rif.ridx = paddr[6:2];

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (rd_setup) begin
            prdata_r <= {16'h0, rd_val};
        end
    end
    assign prdata = prdata_r;

    // control registers, writable whether enabled or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_r <= CTL1_RST;
            ctl2_r <= CTL2_RST;
            ctl3_r <= CTL3_RST;
            l0ctl_r <= '0;
        end else if (wr) begin
            unique case (paddr)
                OFF_CTL1: ctl1_r <= pwdata[15:0] & CTL1_MASK & ~(DW'(1) << B_CAL);
                OFF_CTL2: ctl2_r <= pwdata[15:0] & CTL2_MASK;
                OFF_CTL3: ctl3_r <= pwdata[15:0] & CTL3_MASK;
                OFF_L0CTL: l0ctl_r <= pwdata[15:0] & L0_MASK;
                default: ;
            endcase
        end
    end

    // channel table
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < TBL_N; i++) tbl_r[i] <= '0;
        end else if (wr && in_win(paddr, WIN_TBL)) begin
            tbl_r[paddr[6:2]] <= pwdata[5:0];
        end
    end

    // halt when disabled, idle with stop bit, or sleep without run bit
    assign halt = !ctl1_r[B_EN]
        || (cpu_idle && ctl1_r[B_SIDL])
        || (cpu_sleep && !ctl1_r[B_SLP]);

    pagc_prescaler #(.W(8)) u_psc (
        .pclk(pclk),
        .presetn(presetn),
        .run(!halt),
        .div(ctl3_r[7:0]),
        .tick(tick)
    );

    // calibrate bit: set by write, cleared after two ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_r <= 1'b0;
            cal_cnt_r <= '0;
        end else if (cal_r && tick && cal_cnt_r == CAL_TICKS - 2'h1) begin
            cal_r <= 1'b0;
            cal_cnt_r <= '0;
        end else if (wr && paddr == OFF_CTL1) begin
            cal_r <= pwdata[B_CAL] | (cal_r & ~ctl1_r[B_EN]);
            cal_cnt_r <= '0;
        end else if (cal_r && tick) begin
            cal_cnt_r <= cal_cnt_r + 2'h1;
        end
    end
    assign cal_start = wr && paddr == OFF_CTL1 && pwdata[B_CAL] && !cal_r;

    // analog ready only while enabled, core warm and not calibrating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_r <= 1'b0;
        end else begin
            rdy_r <= ctl1_r[B_EN] && core_ready && !cal_r;
        end
    end

    // list 0 sequencer: one sample per tick (every other tick at prescaler code zero), results counted on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= PAGC_IDLE;
            iss_r <= '0;
            rcv_r <= '0;
            sample_r <= 1'b0;
            chan_r <= '0;
        end else begin
            sample_r <= 1'b0;
            unique case (st_r)
                PAGC_IDLE: begin
                    if (list0_trigger && !halt && rdy_r && l0ctl_r[B_LIST_ENABLE] && ctl3_r[B_LEN]) begin
                        st_r <= PAGC_CONV;
                        iss_r <= '0;
                        rcv_r <= '0;
                    end
                end
                PAGC_CONV: begin
                    if (tick && iss_r <= l0ctl_r[4:0] && !sample_r) begin
                        sample_r <= 1'b1;
                        chan_r <= tbl_r[iss_r];
                        iss_r <= iss_r + 5'h1;
                    end
                    if (core_valid) begin
                        rcv_r <= rcv_r + 5'h1;
                    end
                    if (done || !ctl1_r[B_EN]) begin
                        st_r <= PAGC_IDLE;
                    end
                end
            endcase
        end
    end
    assign done = st_r == PAGC_CONV && core_valid && rcv_r == l0ctl_r[4:0];

    // fifo pointer advances per stored result and wraps at 32
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_r <= '0;
        end else if (rif.we) begin
            fifo_r <= fifo_r + 5'h1;
        end
    end

    // result path into the shared store
    assign rif.we = st_r == PAGC_CONV && core_valid;
    assign rif.widx = ctl2_r[B_ORG] ? rcv_r : fifo_r;
    assign rif.wraw = core_data;
    assign rif.form = ctl1_r[B_FORM+3:B_FORM];

    pagc_result_buf #(.DEPTH(32)) u_res (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif)
    );

    // event flags: set on list done wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l0f_r <= 1'b0;
            irqf_r <= 1'b0;
            irqe_r <= 1'b0;
        end else begin
            if (done) begin
                l0f_r <= 1'b1;
            end else if (wr && paddr == OFF_STATL) begin
                l0f_r <= pwdata[B_L0F];
            end
            if (done) begin
                irqf_r <= 1'b1;
            end else if (wr && paddr == OFF_IRQ) begin
                irqf_r <= pwdata[B_IRQF];
            end
            if (wr && paddr == OFF_IRQ) begin
                irqe_r <= pwdata[B_IRQE];
            end
        end
    end

    // analog controls driven from the registers
    assign core_enable = ctl1_r[B_EN];
    assign switch_pump_enable = ctl1_r[B_SPUMP];
    assign power_level = ctl1_r[B_PWR];
    assign reference_pump_enable = ctl2_r[B_RPUMP];
    assign neg_ref_select = ctl2_r[B_NVREF];
    always_comb begin
        unique case (ctl2_r[B_PVREF+1:B_PVREF])
            2'h2: pos_ref_onehot = REF_BUF1;
            2'h1: pos_ref_onehot = REF_EXT;
            default: pos_ref_onehot = REF_SUP;
        endcase
    end
    assign sample_strobe = sample_r;
    assign sample_channel = chan_r;
    assign conversion_busy = st_r == PAGC_CONV;
    assign analog_ready = rdy_r;
    assign list0_event_flag = l0f_r;
    assign converter_irq_flag = irqf_r;
    assign converter_irq = irqf_r && irqe_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rw_off;
        wr && paddr == OFF_CTL2 && !ctl1_r[B_EN] |=> ctl2_r == ($past(pwdata[15:0]) & CTL2_MASK);
    endproperty
    a_rw_off: assert property (p_rw_off) else $error("write lost while off");
    property p_idle;
        cpu_idle && ctl1_r[B_SIDL] |=> !sample_strobe;
    endproperty
    a_idle: assert property (p_idle) else $error("sampled in idle");
    property p_sleep;
        cpu_sleep && !ctl1_r[B_SLP] |=> !sample_strobe;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sampled in sleep");
    property p_cal_hold;
        $rose(cal_r) |=> cal_r;
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("calibrate too short");
    property p_cal_clr;
        cal_r && tick && cal_cnt_r == 2'h1 |=> !cal_r;
    endproperty
    a_cal_clr: assert property (p_cal_clr) else $error("calibrate not cleared");
    property p_done;
        done |=> list0_event_flag && converter_irq_flag && !conversion_busy;
    endproperty
    a_done: assert property (p_done) else $error("flags not raised");
    property p_ready;
        analog_ready |-> $past(core_enable) && !$past(cal_r);
    endproperty
    a_ready: assert property (p_ready) else $error("ready too early");
    property p_org;
        rif.we && ctl2_r[B_ORG] |-> rif.widx == rcv_r;
    endproperty
    a_org: assert property (p_org) else $error("indexed slot wrong");
    property p_ref;
        ctl2_r[15:14] == 2'h1 |-> pos_ref_onehot == REF_EXT && $onehot(pos_ref_onehot);
    endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");
    c_list: cover property (done);
    c_cal: cover property ($fell(cal_r));
    c_fifo_wrap: cover property (rif.we && fifo_r == 5'h1f);
endmodule

`default_nettype wire

// ===== inc/pagc_pkg.sv
// Purpose: constants for the pipeline converter global control block
// Assumes: 32-bit APB, 16-bit registers in the low half of each word
// Notes: offsets are byte addresses
package pagc_pkg;
    localparam int AW = 12;
    localparam int DW = 16;
    // register byte offsets
    localparam logic [AW-1:0] OFF_CTL1 = 12'h000;
    localparam logic [AW-1:0] OFF_CTL2 = 12'h004;
    localparam logic [AW-1:0] OFF_CTL3 = 12'h008;
    localparam logic [AW-1:0] OFF_STATH = 12'h00c;
    localparam logic [AW-1:0] OFF_STATL = 12'h010;
    localparam logic [AW-1:0] OFF_IRQ = 12'h014;
    localparam logic [AW-1:0] OFF_L0CTL = 12'h018;
    // 32-word windows, selected by address bits 11:7
    localparam logic [4:0] WIN_TBL = 5'h02;
    localparam logic [4:0] WIN_RES = 5'h04;
    // control one fields
    localparam int B_EN = 15;
    localparam int B_SIDL = 13;
    localparam int B_SLP = 12;
    localparam int B_FORM = 8;
    localparam int B_SPUMP = 7;
    localparam int B_CAL = 6;
    localparam int B_PWR = 0;
    // control two fields
    localparam int B_PVREF = 14;
    localparam int B_NVREF = 12;
    localparam int B_ORG = 10;
    localparam int B_RPUMP = 1;
    // control three, status, irq and list fields
    localparam int B_LEN = 8;
    localparam int B_BUSY = 0;
    localparam int B_RDY = 1;
    localparam int B_PST = 2;
    localparam int B_L0F = 0;
    localparam int B_IRQF = 0;
    localparam int B_IRQE = 1;
    localparam int B_LIST_ENABLE = 15;
    // writable masks and reset values
    localparam logic [DW-1:0] CTL1_MASK = 16'hbfc1;
    localparam logic [DW-1:0] CTL2_MASK = 16'hd7c3;
    localparam logic [DW-1:0] CTL3_MASK = 16'h0fff;
    localparam logic [DW-1:0] L0_MASK = 16'h801f;
    localparam logic [DW-1:0] CTL1_RST = 16'h0000;
    localparam logic [DW-1:0] CTL2_RST = 16'h0300;
    localparam logic [DW-1:0] CTL3_RST = 16'h0000;
    // prescaler largest legal code and calibrate hold in ticks
    localparam logic [7:0] PSC_MAX = 8'h10;
    localparam logic [1:0] CAL_TICKS = 2'h2;
    // positive reference one-hot {buffer one, external pin, supply}
    localparam logic [2:0] REF_BUF1 = 3'h4;
    localparam logic [2:0] REF_EXT = 3'h2;
    localparam logic [2:0] REF_SUP = 3'h1;
endpackage

// ===== inc/pagc_res_if.sv
// Purpose: result write and read path between control and result store
// Assumes: one write and one read port
// Notes: raw 12-bit data is formatted in the store
`timescale 1ns/1ps
`default_nettype none
interface pagc_res_if #(parameter int IW = 5) ();
    logic we; // store one result
    logic [IW-1:0] widx; // word written
    logic [11:0] wraw; // raw conversion code
    logic [3:0] form; // output format code
    logic [IW-1:0] ridx; // word read
    logic [15:0] rdata; // formatted word
    modport ctl (output we, widx, wraw, form, ridx, input rdata);
    modport store (input we, widx, wraw, form, ridx, output rdata);
endinterface
`default_nettype wire

// ===== verilog/pagc_prescaler.sv
// Purpose: conversion clock tick from the source clock
// Assumes: source is pclk
// Notes: codes above the legal maximum are clamped to it
`timescale 1ns/1ps
`default_nettype none
module pagc_prescaler #(parameter int W = 8) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [W-1:0] div,
    // one tick per conversion clock period
    output logic tick
);
    import pagc_pkg::*;
    if (W != 8) $error("prescaler width must be 8");
    logic [W:0] cnt_r; // source cycles in this period
    logic [W:0] lim; // last count of the period
    logic [W-1:0] dcl; // clamped code
    // period is twice the code, or one cycle for code zero
    always_comb begin
        dcl = (div > PSC_MAX) ? PSC_MAX : div;
        lim = (dcl == '0) ? '0 : ({dcl, 1'b0} - (W+1)'(1));
    end
    assign tick = run && (cnt_r == lim);
    // count restarts when halted or at each tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (!run || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + (W+1)'(1);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tick_gap;
        tick && div != '0 |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too soon");
endmodule
`default_nettype wire

// ===== verilog/pagc_result_buf.sv
// Purpose: 32-word result store with output formatting
// Assumes: one result written per cycle at most
// Notes: format codes 8 to 15 store raw integer form; codes 4 to 7 repeat the layouts of 0 to 3
`timescale 1ns/1ps
`default_nettype none
module pagc_result_buf #(parameter int DEPTH = 32) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write and read path
    pagc_res_if.store rif
);
    import pagc_pkg::*;
    if (DEPTH != 32) $error("result store depth must be 32");
    logic [15:0] mem_r [DEPTH]; // result words
    // formats a raw code; bit 3 forces raw, else low two bits pick layout; bit 2 is don't care
    function automatic logic [15:0] fmt(input logic [11:0] raw, input logic [3:0] f);
        logic [11:0] s;
        s = raw ^ 12'h800;
        if (f[3]) begin
            fmt = {4'h0, raw};
        end else begin
            unique case (f[1:0])
                2'h0: fmt = {4'h0, raw};
                2'h1: fmt = {{4{s[11]}}, s};
                2'h2: fmt = {raw, 4'h0};
                2'h3: fmt = {s, 4'h0};
            endcase
        end
    endfunction
    // write formatted result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
        end else if (rif.we) begin
            mem_r[rif.widx] <= fmt(rif.wraw, rif.form);
        end
    end
    assign rif.rdata = mem_r[rif.ridx];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_fmt;
        rif.we && rif.form == 4'h2 |=> mem_r[$past(rif.widx)] == {$past(rif.wraw), 4'h0};
    endproperty
    a_fmt: assert property (p_fmt) else $error("fraction layout wrong");
endmodule
`default_nettype wire

// ===== verif/test_pagc_top.sv
// Purpose: self-checking bench for the converter global control block
// Assumes: zero-wait apb slave; prescaler 5 gives a 10 mhz conversion clock
// Notes: core stand-in answers each strobe one cycle later
`timescale 1ns/1ps
`default_nettype none
module test_pagc_top;
    import pagc_pkg::*;
    // apb side
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er;
    // power state, trigger and core side
    logic cpu_idle = 0, cpu_sleep = 0, list0_trigger = 0, core_ready = 1, core_valid = 0;
    logic [11:0] core_data = '0;
    logic core_enable, cal_start, sample_strobe, switch_pump_enable, reference_pump_enable;
    logic power_level, neg_ref_select, conversion_busy, analog_ready;
    logic list0_event_flag, converter_irq_flag, converter_irq;
    logic [5:0] sample_channel;
    logic [2:0] pos_ref_onehot;
    int error_cnt = 0, n_checks = 0, n_cal = 0, n_strb = 0;

    pagc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cpu_idle, .cpu_sleep, .list0_trigger, .core_ready, .core_valid,
        .core_data, .core_enable, .cal_start, .sample_strobe, .sample_channel,
        .switch_pump_enable, .reference_pump_enable, .power_level, .neg_ref_select,
        .pos_ref_onehot, .conversion_busy, .analog_ready, .list0_event_flag,
        .converter_irq_flag, .converter_irq);

    // 100 mhz clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    // core stand-in: result carries its channel, counts strobes and cal pulses
    always @(posedge pclk) begin
        core_valid <= sample_strobe;
        core_data <= 12'h3a0 | {6'h0, sample_channel};
        if (cal_start) n_cal++;
        if (sample_strobe) n_strb++;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [AW-1:0] a, input logic [15:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        // let the write land before callers look at outputs
        @(negedge pclk);
    endtask

    task rchk(input logic [AW-1:0] a, input logic [15:0] e);
        apb(0, a, 16'h0);
        chk(rd, {16'h0, e});
    endtask

    // bounded wait: 0 for analog ready, 1 for list event flag
    task wait_on(input int which);
        int k;
        k = 0;
        while ((which ? list0_event_flag : analog_ready) !== 1'b1 && k < 500) begin
            @(posedge pclk);
            k++;
        end
        if ((which ? list0_event_flag : analog_ready) !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task trig;
        @(posedge pclk);
        list0_trigger <= 1;
        @(posedge pclk);
        list0_trigger <= 0;
    endtask

    // expected word for a format code and raw code
    function automatic logic [15:0] fmt(input logic [3:0] c, input logic [11:0] r);
        logic [11:0] s;
        s = r ^ 12'h800;
        case (c[1:0])
            2'h1: fmt = {{4{s[11]}}, s};
            2'h2: fmt = {r, 4'h0};
            2'h3: fmt = {s, 4'h0};
            default: fmt = {4'h0, r};
        endcase
    endfunction

    // run list 0 once under a control one value, then clear flags
    task run_list(input logic [15:0] c1);
        apb(1, OFF_CTL1, c1);
        trig();
        wait_on(1);
        chk({converter_irq_flag, converter_irq, conversion_busy}, 3'b110);
        apb(1, OFF_STATL, 16'h0);
        apb(1, OFF_IRQ, 16'h2);
        chk(list0_event_flag, 0);
    endtask

    task t_reset;
        rchk(OFF_CTL1, CTL1_RST);
        rchk(OFF_CTL2, 16'h0300);
        chk({pos_ref_onehot, analog_ready}, 4'h2);
        apb(0, 12'h0fc, 16'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
    endtask

    // references and pumps, written while disabled
    task t_refs;
        logic [2:0] exp [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
        for (int i = 0; i < 4; i++) begin
            apb(1, OFF_CTL2, {i[1:0], 14'h1302});
            chk(pos_ref_onehot, exp[i]);
            rchk(OFF_CTL2, {i[1:0], 14'h1302});
        end
        chk({neg_ref_select, reference_pump_enable}, 2'h3);
        apb(1, OFF_CTL1, 16'h4081);
        rchk(OFF_CTL1, 16'h0081);
        chk({switch_pump_enable, power_level, core_enable}, 3'h6);
        rchk(OFF_STATH, 16'h0004);
    endtask

    // enable with calibration, then set up list 0 in fifo organisation
    task t_bring;
        apb(1, OFF_CTL2, 16'h0300);
        apb(1, OFF_CTL3, 16'h0f05);
        rchk(OFF_CTL3, 16'h0f05);
        apb(1, OFF_CTL1, 16'h0001);
        // core not yet warm: ready must stay low after calibration
        @(posedge pclk);
        core_ready <= 0;
        apb(1, OFF_CTL1, 16'h8041);
        chk(n_cal, 1);
        repeat (30) @(posedge pclk);
        chk(analog_ready, 0);
        core_ready <= 1;
        rchk(OFF_CTL1, 16'h8001);
        wait_on(0);
        rchk(OFF_STATH, 16'h0002);
        apb(1, OFF_L0CTL, 16'h0001);
        apb(1, 12'h100, 16'h0005);
        apb(1, 12'h104, 16'h002a);
        apb(1, OFF_STATL, 16'h0000);
        apb(1, OFF_IRQ, 16'h0002);
        apb(1, OFF_L0CTL, 16'h8001);
        rchk(OFF_L0CTL, 16'h8001);
        rchk(12'h104, 16'h002a);
        run_list(16'h8001);
        rchk(OFF_IRQ, 16'h0002);
        run_list(16'h8001);
        chk(n_strb, 4);
        rchk(12'h208, 16'h03a5);
        rchk(12'h20c, 16'h03aa);
    endtask

    // indexed organisation through format codes 0 to 7
    task t_fmt;
        apb(1, OFF_CTL2, 16'h0700);
        for (int f = 0; f < 8; f++) begin
            run_list({4'h8, f[3:0], 8'h01});
            rchk(12'h200, fmt(f[3:0], 12'h3a5));
            rchk(12'h204, fmt(f[3:0], 12'h3aa));
        end
    endtask

    // idle and sleep gating of triggers
    task t_power;
        apb(1, OFF_CTL1, 16'ha001);
        @(posedge pclk);
        cpu_idle <= 1;
        trig();
        repeat (20) @(posedge pclk);
        chk({conversion_busy, list0_event_flag, n_strb[7:0]}, 10'd20);
        run_list(16'h8001);
        @(posedge pclk);
        cpu_idle <= 0;
        cpu_sleep <= 1;
        apb(1, OFF_CTL1, 16'h8001);
        trig();
        repeat (20) @(posedge pclk);
        chk({conversion_busy, list0_event_flag, n_strb[7:0]}, 10'd22);
        run_list(16'h9001);
        chk(n_strb, 24);
    endtask

    // watchdog
    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_refs();
        t_bring();
        t_fmt();
        t_power();
        wrap_up();
    end
endmodule
`default_nettype wire
